// ---- verilog/otp_pkg.sv ----
// package for the output test pattern generator
// assumes one pixel clock domain and byte-wide registers at 6-bit addresses
`default_nettype none

package otp_pkg;

    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int ADDR_W = 6;   // register address width
    localparam int CODE_W = 14;  // output code width
    localparam int LFSR_W = 15;  // pseudo-random register length

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [5:0] OFF_START_HI = 6'h30; // pattern_start_high
    localparam logic [5:0] OFF_START_LO = 6'h31; // pattern_start_low
    localparam logic [5:0] OFF_WIDTH_HI = 6'h32; // region_width_high
    localparam logic [5:0] OFF_WIDTH_LO = 6'h33; // region_width_low
    localparam logic [5:0] OFF_CTRL     = 6'h34; // generator_control
    localparam logic [5:0] OFF_SPACING  = 6'h35; // pattern_spacing
    localparam logic [5:0] OFF_INCR     = 6'h36; // pattern_increment
    localparam logic [5:0] OFF_CH2_DLY  = 6'h37; // second_channel_line_delay
    localparam logic [5:0] OFF_CODE_HI  = 6'h38; // pattern_code_high
    localparam logic [5:0] OFF_CODE_LO  = 6'h39; // pattern_code_low

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00; // every register
    localparam logic [3:0] RST_DLY  = 4'h0;  // channel 2 delay field
    localparam logic [5:0] RST_LOW6 = 6'h00; // low six code bits

    // -----------------------------------------------------------------
    // control field positions
    // -----------------------------------------------------------------
    localparam int CTL_SWITCH = 7; // pattern switch
    localparam int CTL_MODE_H = 6; // mode field top
    localparam int CTL_MODE_L = 4; // mode field bottom
    localparam int CTL_PRBS   = 3; // pseudo-random enable
    localparam int CTL_SEED   = 2; // load seed enable
    localparam int CTL_SEL_H  = 1; // channel select top

    // channel select codes
    localparam logic [1:0] SEL_BOTH = 2'h0;
    localparam logic [1:0] SEL_CH1  = 2'h1;
    localparam logic [1:0] SEL_CH2  = 2'h2;

    // lfsr taps x^15 + x^14 + 1, counted from zero
    localparam int LFSR_TAP_A = 14;
    localparam int LFSR_TAP_B = 13;
    localparam logic [14:0] LFSR_ONE = 15'h0001; // substitute for zero seed

    // pattern modes, encoded 0..7 in listed order
    typedef enum logic [2:0] {
        MODE_FIXED, MODE_HGRAD, MODE_VGRAD, MODE_LATTICE,
        MODE_STRIPE, MODE_LINK_SYNC, MODE_LINK_FREE, MODE_UNUSED
    } otp_mode_t;

    // one pixel pair, channel 1 and channel 2
    typedef struct packed {
        logic [CODE_W-1:0] ch1;
        logic [CODE_W-1:0] ch2;
    } otp_pix_t;

endpackage

`default_nettype wire

// ---- verilog/otp_pair_buf.sv ----
// two-entry buffer with valid/ready on both sides
// assumes one clock; in_ready_o falls only when both entries hold data
`timescale 1ns/10ps
`default_nettype none

module otp_pair_buf #(
    parameter int WIDTH = 28 // word width
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;  // two words
        logic                  wptr; // next slot to fill
        logic                  rptr; // next slot to drain
        logic [1:0]            cnt;  // words held
    } otp_buf_state_t;

    otp_buf_state_t st_ff;  // registered state
    otp_buf_state_t nxt_st; // next state
    logic           push;   // word taken
    logic           pop;    // word given

    // next state
    always_comb
    begin
        nxt_st      = st_ff;
        in_ready_o  = (st_ff.cnt != 2'h2);
        out_valid_o = (st_ff.cnt != 2'h0);
        out_data_o  = st_ff.mem[st_ff.rptr];
        push        = in_valid_i & in_ready_o;
        pop         = out_valid_o & out_ready_i;
        if (push)
        begin
            nxt_st.mem[st_ff.wptr] = in_data_i;
            nxt_st.wptr            = ~st_ff.wptr;
        end
        if (pop)
        begin
            nxt_st.rptr = ~st_ff.rptr;
        end
        // count follows push and pop together
        if (push && !pop)
        begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
        else if (pop && !push)
        begin
            nxt_st.cnt = st_ff.cnt - 2'h1;
        end
    end

    // register
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule // otp_pair_buf

`default_nettype wire

// ---- verilog/otp_gen.sv ----
// output test pattern generator: replaces pixel pairs by synthetic codes
// assumes adc pairs on clk_i, line sync from a pin, byte register port
//
// Function
// - 16-bit start count in two bytes
// - 16-bit region width in two bytes
// - switch bit selects pattern over normal data
// - 3-bit mode field selects pattern kind
// - pseudo-random enable beats pattern switch
// - load seed into lfsr at line edge
// - channel select routes pattern to channels
// - pitch sets pixel and line spacing
// - gradients increase by step each pitch
// - lattice/stripe low code from step register
// - channel 2 delayed by offset lines
// - value is fixed, start or high code
// - low six value bits at next address
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module otp_gen (
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic [5:0]              reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic [7:0]                   reg_rdata_o,
    input  wire logic                    line_sync_input_i,
    input  wire logic                    adc_valid_i,
    output logic                         adc_ready_o,
    input  wire otp_pkg::otp_pix_t       adc_data_i,
    output logic                         out_valid_o,
    input  wire logic                    out_ready_i,
    output otp_pkg::otp_pix_t            out_data_o
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        sync1;     // line sync first stage
        logic        sync2;     // line sync second stage
        logic        sync_prev; // for edge detect
        logic [15:0] start;     // region start
        logic [15:0] width;     // region width
        logic [7:0]  ctrl;      // control byte
        logic [7:0]  pitch;     // spacing
        logic [7:0]  step;      // increment / low code
        logic [3:0]  dly;       // channel 2 line delay
        logic [13:0] value;     // high code / seed
        logic [7:0]  rdata;     // read answer
        logic [15:0] pix;       // pixels since line edge
        logic [7:0]  h_cnt;     // pixel within pitch
        logic [13:0] h_code;    // horizontal gradient code
        logic        h_phase;   // stripe phase
        logic        s_phase;   // synced link test phase
        logic        f_phase;   // free link test phase
        logic [4:0]  lines;     // line edges since enable
        logic [1:0][7:0]  v_cnt;  // line within pitch, per channel
        logic [1:0][13:0] v_code; // vertical gradient code, per channel
        logic [14:0] lfsr;      // pseudo-random register
    } otp_gen_state_t;

    otp_gen_state_t    st_ff;    // registered state
    otp_gen_state_t    nxt_st;   // next state
    logic              edge_w;   // line sync leading edge
    logic              gen_on;   // switch or prbs set
    logic              accept;   // pixel taken this cycle
    logic              in_reg;   // pixel inside valid region
    logic [15:0]       idx;      // pixel index of this cycle
    logic [14:0]       seed;     // lfsr seed from value
    otp_pkg::otp_pix_t buf_in;   // word entering the buffer
    logic              buf_rdy;  // buffer can take a word
    otp_pkg::otp_mode_t mode;    // decoded mode

    // -----------------------------------------------------------------
    // pattern code for one channel
    // -----------------------------------------------------------------
    function automatic logic [13:0] pat_code(
        input otp_pkg::otp_mode_t m,
        input otp_gen_state_t     s,
        input logic [7:0]         vc,
        input logic [13:0]        vcode,
        input logic [13:0]        dflt
    );
        logic [13:0] low;
        low = {6'h00, s.step};
        case (m)
            otp_pkg::MODE_FIXED:     pat_code = s.value;
            otp_pkg::MODE_HGRAD:     pat_code = s.h_code;
            otp_pkg::MODE_VGRAD:     pat_code = vcode;
            // grid lines high, cells low
            otp_pkg::MODE_LATTICE:   pat_code = (s.h_cnt == 8'h00 || vc == 8'h00)
                                                ? s.value : low;
            otp_pkg::MODE_STRIPE:    pat_code = s.h_phase ? low : s.value;
            otp_pkg::MODE_LINK_SYNC: pat_code = s.s_phase ? ~s.value : s.value;
            otp_pkg::MODE_LINK_FREE: pat_code = s.f_phase ? ~s.value : s.value;
            default:                 pat_code = dflt; // unused code passes data
        endcase
    endfunction

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb
    begin
        logic [8:0]  h_next;
        logic [8:0]  v_next;
        logic [16:0] diff;
        logic        use_ch;
        logic [13:0] code;
        logic [13:0] raw;
        h_next = 9'h000;
        v_next = 9'h000;
        diff   = 17'h00000;
        use_ch = 1'b0;
        code   = 14'h0000;
        raw    = 14'h0000;
        nxt_st = st_ff;
        // synchroniser and edge
        nxt_st.sync1     = line_sync_input_i;
        nxt_st.sync2     = st_ff.sync1;
        nxt_st.sync_prev = st_ff.sync2;
        edge_w  = st_ff.sync2 & ~st_ff.sync_prev;
        gen_on  = st_ff.ctrl[otp_pkg::CTL_SWITCH] | st_ff.ctrl[otp_pkg::CTL_PRBS];
        mode    = otp_pkg::otp_mode_t'(st_ff.ctrl[otp_pkg::CTL_MODE_H:otp_pkg::CTL_MODE_L]);
        accept  = adc_valid_i & buf_rdy;
        seed    = ({1'b0, st_ff.value} == 15'h0000) ? otp_pkg::LFSR_ONE
                                                   : {1'b0, st_ff.value};
        // pixel index restarts at the edge
        idx  = edge_w ? 16'h0000 : st_ff.pix;
        diff = {1'b0, idx} - {1'b0, st_ff.start};
        in_reg = (idx >= st_ff.start) && (diff < {1'b0, st_ff.width});
        nxt_st.pix = idx;
        if (accept && idx != 16'hFFFF)
        begin
            nxt_st.pix = idx + 16'h0001;
        end
        // line edge: restart horizontal trackers
        if (edge_w)
        begin
            nxt_st.h_cnt   = 8'h00;
            nxt_st.h_code  = st_ff.value;
            nxt_st.h_phase = 1'b0;
            nxt_st.s_phase = 1'b0;
            if (st_ff.lines != 5'h1F)
            begin
                nxt_st.lines = st_ff.lines + 5'h01;
            end
            // vertical trackers; channel 2 waits dly extra lines
            for (int c = 0; c < 2; c++)
            begin
                v_next = {1'b0, st_ff.v_cnt[c]} + 9'h001;
                if (st_ff.lines >= ((c == 1) ? {1'b0, st_ff.dly} + 5'h01 : 5'h01))
                begin
                    if (v_next >= {1'b0, st_ff.pitch})
                    begin
                        nxt_st.v_cnt[c]  = 8'h00;
                        nxt_st.v_code[c] = st_ff.v_code[c] + {6'h00, st_ff.step};
                    end
                    else
                    begin
                        nxt_st.v_cnt[c] = v_next[7:0];
                    end
                end
            end
        end
        // generator off: frame restarts at next enable
        if (!gen_on)
        begin
            nxt_st.lines = 5'h00;
            for (int c = 0; c < 2; c++)
            begin
                nxt_st.v_cnt[c]  = 8'h00;
                nxt_st.v_code[c] = st_ff.value;
            end
        end
        // lfsr: seed at edge, else step per pixel
        if (edge_w && st_ff.ctrl[otp_pkg::CTL_SEED])
        begin
            nxt_st.lfsr = seed;
        end
        else if (accept)
        begin
            nxt_st.lfsr = {st_ff.lfsr[13:0],
                           st_ff.lfsr[otp_pkg::LFSR_TAP_A] ^ st_ff.lfsr[otp_pkg::LFSR_TAP_B]};
        end
        // per-channel output word; horizontal trackers seen after any edge restart, vertical ones as registered
        buf_in = adc_data_i;
        for (int c = 0; c < 2; c++)
        begin
            raw    = (c == 0) ? adc_data_i.ch1 : adc_data_i.ch2;
            use_ch = (st_ff.ctrl[otp_pkg::CTL_SEL_H:0] == otp_pkg::SEL_BOTH) ||
                     (st_ff.ctrl[otp_pkg::CTL_SEL_H:0] == ((c == 0) ? otp_pkg::SEL_CH1
                                                                   : otp_pkg::SEL_CH2));
            if (st_ff.ctrl[otp_pkg::CTL_PRBS])
            begin
                code = st_ff.lfsr[13:0];
            end
            else
            begin
                code = pat_code(mode, nxt_st, st_ff.v_cnt[c], st_ff.v_code[c], raw);
            end
            if (!(gen_on && in_reg && use_ch))
            begin
                code = raw;
            end
            if (c == 0)
            begin
                buf_in.ch1 = code;
            end
            else
            begin
                buf_in.ch2 = code;
            end
        end
        // horizontal trackers advance per pixel inside the region; link test phases flip on every accepted pixel
        if (accept)
        begin
            nxt_st.s_phase = ~nxt_st.s_phase;
            nxt_st.f_phase = ~st_ff.f_phase;
            if (in_reg)
            begin
                h_next = {1'b0, nxt_st.h_cnt} + 9'h001;
                if (h_next >= {1'b0, st_ff.pitch})
                begin
                    nxt_st.h_cnt   = 8'h00;
                    nxt_st.h_code  = nxt_st.h_code + {6'h00, st_ff.step};
                    nxt_st.h_phase = ~nxt_st.h_phase;
                end
                else
                begin
                    nxt_st.h_cnt = h_next[7:0];
                end
            end
        end
        // register writes
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                otp_pkg::OFF_START_HI: nxt_st.start[15:8] = reg_wdata_i;
                otp_pkg::OFF_START_LO: nxt_st.start[7:0]  = reg_wdata_i;
                otp_pkg::OFF_WIDTH_HI: nxt_st.width[15:8] = reg_wdata_i;
                otp_pkg::OFF_WIDTH_LO: nxt_st.width[7:0]  = reg_wdata_i;
                otp_pkg::OFF_CTRL:     nxt_st.ctrl        = reg_wdata_i;
                otp_pkg::OFF_SPACING:  nxt_st.pitch       = reg_wdata_i;
                otp_pkg::OFF_INCR:     nxt_st.step        = reg_wdata_i;
                otp_pkg::OFF_CH2_DLY:  nxt_st.dly         = reg_wdata_i[3:0];
                otp_pkg::OFF_CODE_HI:  nxt_st.value[13:6] = reg_wdata_i;
                otp_pkg::OFF_CODE_LO:  nxt_st.value[5:0]  = reg_wdata_i[5:0];
                default:               nxt_st.value       = nxt_st.value; // unmapped ignored
            endcase
        end
        // register reads, answer stands one cycle
        nxt_st.rdata = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                otp_pkg::OFF_START_HI: nxt_st.rdata = st_ff.start[15:8];
                otp_pkg::OFF_START_LO: nxt_st.rdata = st_ff.start[7:0];
                otp_pkg::OFF_WIDTH_HI: nxt_st.rdata = st_ff.width[15:8];
                otp_pkg::OFF_WIDTH_LO: nxt_st.rdata = st_ff.width[7:0];
                otp_pkg::OFF_CTRL:     nxt_st.rdata = st_ff.ctrl;
                otp_pkg::OFF_SPACING:  nxt_st.rdata = st_ff.pitch;
                otp_pkg::OFF_INCR:     nxt_st.rdata = st_ff.step;
                otp_pkg::OFF_CH2_DLY:  nxt_st.rdata = {4'h0, st_ff.dly};
                otp_pkg::OFF_CODE_HI:  nxt_st.rdata = st_ff.value[13:6];
                otp_pkg::OFF_CODE_LO:  nxt_st.rdata = {2'h0, st_ff.value[5:0]};
                default:               nxt_st.rdata = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // register
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_ff      <= '0;
            st_ff.lfsr <= otp_pkg::LFSR_ONE; // never all zero
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o = st_ff.rdata;
    assign adc_ready_o = buf_rdy;

    // -----------------------------------------------------------------
    // output buffer
    // -----------------------------------------------------------------
    otp_pair_buf #(
        .WIDTH      ($bits(otp_pkg::otp_pix_t))
    ) u_buf (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (adc_valid_i),
        .in_ready_o  (buf_rdy),
        .in_data_i   (buf_in),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_data_o)
    );

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_seed_req;
        edge_w && st_ff.ctrl[otp_pkg::CTL_SEED];
    endsequence

    sequence s_gen_px;
        accept && in_reg && st_ff.ctrl[1:0] == otp_pkg::SEL_BOTH;
    endsequence

    a_start_high: assert property (reg_wr_i && reg_addr_i == otp_pkg::OFF_START_HI
        |=> st_ff.start[15:8] == $past(reg_wdata_i)) else $error("start high not stored");
    a_width_read: assert property (reg_wr_i && reg_addr_i == otp_pkg::OFF_WIDTH_LO ##1
        reg_rd_i && reg_addr_i == otp_pkg::OFF_WIDTH_LO && !reg_wr_i
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("width readback wrong");
    a_normal_pass: assert property (accept && !gen_on
        |-> buf_in == adc_data_i) else $error("normal data altered");
    a_fixed_code: assert property (s_gen_px and (st_ff.ctrl[7:3] == 5'h10)
        |-> buf_in.ch1 == st_ff.value) else $error("fixed code wrong");
    a_prbs_wins: assert property (s_gen_px and st_ff.ctrl[otp_pkg::CTL_PRBS]
        |-> buf_in.ch2 == st_ff.lfsr[13:0]) else $error("prbs not chosen");
    a_seed_load: assert property (s_seed_req |=> st_ff.lfsr == $past(seed))
        else $error("seed not loaded");
    a_ch1_only: assert property (accept && st_ff.ctrl[1:0] == otp_pkg::SEL_CH1
        |-> buf_in.ch2 == adc_data_i.ch2) else $error("channel 2 not passed");
    a_stripe_low: assert property (s_gen_px and (st_ff.ctrl[7:3] == 5'h18) and
        (nxt_st.h_phase == st_ff.h_phase) and st_ff.h_phase and !edge_w
        |-> buf_in.ch1 == {6'h00, st_ff.step}) else $error("stripe low code wrong");
    a_delay_mask: assert property (reg_rd_i && reg_addr_i == otp_pkg::OFF_CH2_DLY
        |=> reg_rdata_o[7:4] == 4'h0) else $error("delay upper bits set");
    a_low_six: assert property (reg_wr_i && reg_addr_i == otp_pkg::OFF_CODE_LO
        |=> st_ff.value[5:0] == $past(reg_wdata_i[5:0])) else $error("low code bits");
    a_outside_pass: assert property (accept && !in_reg
        |-> buf_in == adc_data_i) else $error("data changed outside region");

endmodule // otp_gen

`default_nettype wire

// ---- sim/otp_rx_model.sv ----
// receiver model for the generator's pixel stream
// assumes one clock; stall_i holds ready low so the buffer fills
`timescale 1ns/10ps
`default_nettype none

module otp_rx_model (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              stall_i,
    input  wire logic              out_valid_i,
    input  wire otp_pkg::otp_pix_t out_data_i,
    output logic                   out_ready_o
);
    otp_pkg::otp_pix_t got_q [$]; // accepted words, oldest first

    // ready follows the stall request, low in reset
    assign out_ready_o = ~stall_i & ~reset_i;

    // keep every accepted word in arrival order
    always @(posedge clk_i)
    begin
        if (!reset_i && out_valid_i && out_ready_o)
            got_q.push_back(out_data_i);
    end
endmodule // otp_rx_model

`default_nettype wire

// ---- sim/otp_gen_tb.sv ----
// self-checking bench for the test pattern generator
// assumes otp_gen and the receiver model, 25 MHz clock
`timescale 1ns/10ps
`default_nettype none

module otp_gen_tb;
    logic              clk_i, reset_i, reg_wr_i, reg_rd_i;
    logic              line_sync_input_i, adc_valid_i, rx_stall;
    logic [5:0]        reg_addr_i;
    logic [7:0]        reg_wdata_i, reg_rdata_o;
    logic              adc_ready_o, out_valid_o, out_ready_i;
    otp_pkg::otp_pix_t adc_data_i, out_data_o;
    int                bad_count, checks_done;
    logic [27:0]       e [8];   // expected words of one line

    otp_gen dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .line_sync_input_i(line_sync_input_i),
        .adc_valid_i(adc_valid_i), .adc_ready_o(adc_ready_o), .adc_data_i(adc_data_i),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o));
    otp_rx_model rx (.clk_i(clk_i), .reset_i(reset_i), .stall_i(rx_stall),
        .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_ready_o(out_ready_i));

    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic summarize();
        $display("mismatches %0d checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [27:0] g, input logic [27:0] x);
        checks_done++;
        if (g !== x)
        begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, x);
        end
    endtask
    function automatic logic [27:0] pd(input int k);
        return {14'(k + 16), 14'(k + 48)};   // adc pair number k
    endfunction
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [5:0] a, input logic [7:0] x);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk({20'h0, reg_rdata_o}, {20'h0, x});
        @(posedge clk_i);
    endtask
    // write every register, default expectation is pass-through
    task automatic cfg(input logic [7:0] st, wd, ct, pi, sp, vh, vl);
        int k;
        for (k = 0; k < 8; k++)
            e[k] = pd(k);
        wr(6'h30, 8'h00);
        wr(6'h31, st);
        wr(6'h32, 8'h00);
        wr(6'h33, wd);
        wr(6'h34, ct);
        wr(6'h35, pi);
        wr(6'h36, sp);
        wr(6'h37, 8'h00);
        wr(6'h38, vh);
        wr(6'h39, vl);
    endtask
    // wait until the generator takes the pair on offer
    task automatic wt();
        int n;
        @(negedge clk_i);
        for (n = 0; n < 40 && adc_ready_o !== 1'b1; n++)
            @(negedge clk_i);
        if (adc_ready_o !== 1'b1)
        begin
            bad_count++;
            summarize();
        end
        @(posedge clk_i);
    endtask
    // one line: sync pulse, n pairs, optional receiver stall, compare
    task automatic line(input int n, input logic st);
        int k;
        rx.got_q.delete();
        rx_stall <= st;
        line_sync_input_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        line_sync_input_i <= 1'b0;
        adc_valid_i <= 1'b1;
        for (k = 0; k < n; k++)
        begin
            adc_data_i <= pd(k);
            wt();
            if (st && k == 1)
            begin
                @(negedge clk_i);
                chk({27'h0, adc_ready_o}, 28'h0);   // full buffer refuses a third
                @(posedge clk_i);
                rx_stall <= 1'b0;
            end
        end
        adc_valid_i <= 1'b0;
        for (k = 0; k < 40 && rx.got_q.size() < n; k++)
            @(posedge clk_i);
        if (rx.got_q.size() < n)
        begin
            bad_count++;
            summarize();
        end
        for (k = 0; k < n; k++)
            chk(rx.got_q[k], e[k]);
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic s_regs();
        int i;
        for (i = 0; i < 10; i++)
            rc(6'h30 + 6'(i), 8'h00);
        for (i = 0; i < 10; i++)
            wr(6'h30 + 6'(i), 8'hF5);
        for (i = 0; i < 10; i++)
            rc(6'h30 + 6'(i), i == 7 ? 8'h05 : i == 9 ? 8'h35 : 8'hF5);
        wr(6'h3A, 8'hFF);
        rc(6'h3A, 8'h00);
        // write then read the same byte with no idle cycle between
        reg_addr_i  <= 6'h33;
        reg_wdata_i <= 8'h5A;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        rc(6'h33, 8'h5A);
    endtask
    task automatic s_fixed();
        int s;
        int k;
        for (s = 0; s < 3; s++)
        begin
            cfg(8'h01, 8'h02, 8'h80 | 8'(s), 8'h00, 8'h00, 8'hAB, 8'h15);
            for (k = 1; k < 3; k++)
            begin
                if (s != 2)
                    e[k][27:14] = 14'h2AD5;
                if (s != 1)
                    e[k][13:0] = 14'h2AD5;
            end
            line(4, 1'b0);
        end
    endtask
    task automatic s_shape();
        int k;
        cfg(8'h00, 8'h06, 8'hC0, 8'h02, 8'h07, 8'hAB, 8'h15);
        for (k = 0; k < 6; k++)
            e[k] = (k / 2) % 2 ? {14'h0007, 14'h0007} : {14'h2AD5, 14'h2AD5};
        line(6, 1'b0);
        cfg(8'h00, 8'h03, 8'h90, 8'h01, 8'h03, 8'hFF, 8'h3E);
        for (k = 0; k < 3; k++)
            e[k] = {2{14'h3FFE + 14'(3 * k)}};
        line(3, 1'b0);
        // synced link test: value and its inverse alternate per pixel
        cfg(8'h00, 8'h04, 8'hD0, 8'h00, 8'h00, 8'hAB, 8'h15);
        for (k = 0; k < 4; k++)
            e[k] = k % 2 ? {2{14'h152A}} : {2{14'h2AD5}};
        line(4, 1'b0);
        // pseudo-random over the switch, seed 5 loaded at the line edge
        cfg(8'h00, 8'h03, 8'h8C, 8'h00, 8'h00, 8'h00, 8'h05);
        for (k = 0; k < 3; k++)
            e[k] = {2{14'(5 << k)}};
        line(3, 1'b0);
        cfg(8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        line(3, 1'b1);
    endtask

    // -----------------------------------------------------------------
    // clock, reset and sequence
    // -----------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        {reset_i, reg_wr_i, reg_rd_i, line_sync_input_i, adc_valid_i} = 5'h10;
        {rx_stall, reg_addr_i, reg_wdata_i, adc_data_i} = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        s_regs();
        s_fixed();
        s_shape();
        summarize();
    end
endmodule // otp_gen_tb

`default_nettype wire
